// file: ffb_fuse_ctrl.sv
// Function
// - Fuses 15:0 are region lock bits
// - Lock/unlock commands also change fuses 15:0
// - Fuse 16 drives external-fetch block
// - Fetch fuse frozen while security set
// - Fuses 19:17 decode boot page range
// - Boot pages refuse internal erase/program
// - Boot fuses change only when unsecured
// - Fuses 21:20 decode trusted state/debug
// - Fuse 22 low enables debug window
// - Bit commands use page field as index
// - Byte program: index 2:0, value 10:3
// - Byte 2 program refused when secured
// - Erase-all fuses refused when secured
// - Bad key/command sets bad command flag
// - Secured special fuse change: lock error
// - Trusted fuse change in trusted mode refused
// - Fuse commands plus one readable fuse register
// - Erased lock fuse means region unlocked
// - Key 0xA5 required in top byte
// - Done flag clears on command, sets after
`default_nettype none
module ffb_fuse_ctrl
   import ffb_pkg::*;
(
   input  wire logic                    clk_i,         // 200 MHz clock
   input  wire logic                    rst_n_i,       // Sync reset, active low
   input  wire logic [FFB_ADDR_W-1:0]   addr_i,        // Register byte address
   input  wire logic [31:0]             wdata_i,       // Write data
   input  wire logic                    wr_i,          // Write strobe
   input  wire logic                    rd_i,          // Read strobe
   input  wire logic                    security_i,    // Security bit state
   input  wire logic [FFB_PAGE_W-1:0]   access_page_i, // Page of an array access
   input  wire logic                    access_req_i,  // Array erase/program request
   output logic [31:0]                  rdata_o,       // Read data, one cycle later
   output logic                         access_deny_o, // Array access refused
   output logic [FFB_LOCK_W-1:0]        region_locked_o, // Region lock states
   output logic                         offchip_fetch_block_o, // External fetch block
   output logic                         trusted_state_enable_o, // Trusted state
   output logic                         trusted_debug_enable_o, // Trusted debug
   output logic                         debug_window_en_o // Debug user protection
);
   import ffb_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   ffb_state_t                 state_reg;
   logic [FFB_FUSE_W-1:0]      fuse_reg;
   logic [FFB_FUSE_W-1:0]      fuse_next;
   logic [FFB_FUSE_W-1:0]      pend_reg;
   logic [FFB_PAGE_W-1:0]      page_reg;
   logic [FFB_CMD_W-1:0]       cmd_reg;
   logic                       op_done_flag_reg;
   logic                       bad_command_flag_reg;
   logic                       protection_violation_flag_reg;
   logic                       ctrl_done_ie_reg;
   logic [7:0]                 timer_reg;

   logic [FFB_LOCK_W-1:0]      lock_w;
   logic                       fetch_w;
   logic [7:0]                 boot_pages_w;
   logic                       tse_w;
   logic                       tde_w;
   logic                       dbg_w;

   ffb_decode u_dec (
      .fuse_i                 (fuse_reg),
      .region_locked_o        (lock_w),
      .offchip_fetch_block_o  (fetch_w),
      .boot_pages_o           (boot_pages_w),
      .trusted_state_enable_o (tse_w),
      .trusted_debug_enable_o (tde_w),
      .debug_window_en_o      (dbg_w)
   );

   // ==========================================================
   // Command checks
   // ==========================================================
   logic        cmd_wr;
   logic        key_ok;
   logic        code_ok;
   logic [5:0]  wcmd;
   logic [15:0] wpage;
   logic        guard_err;
   logic [FFB_FUSE_W-1:0] pend_next;
   logic [FFB_FUSE_W-1:0] touch_mask;

   function automatic logic [FFB_FUSE_W-1:0] ffb_special_mask(input logic secured,
                                                            input logic trusted);
      logic [FFB_FUSE_W-1:0] m;
      m = '0;
      if (secured)
      begin
         m[FFB_FETCH_POS] = 1'b1;
         m[FFB_BOOT_LSB +: FFB_BOOT_W] = 3'h7;
         m[FFB_DBG_POS] = 1'b1;
      end
      if (trusted)
         m[FFB_SEC_LSB +: 2] = 2'h3;
      return m;
   endfunction

   // One address compare shared by the write, clear and read paths
   function automatic logic ffb_reg_hit(input logic [FFB_ADDR_W-1:0] a,
                                        input logic [FFB_ADDR_W-1:0] off);
      return (a == off);
   endfunction

   assign cmd_wr  = wr_i && ffb_reg_hit(addr_i, FFB_OFF_CMD);
   assign wcmd    = wdata_i[FFB_CMD_W-1:0];
   assign wpage   = wdata_i[FFB_PAGE_LSB +: FFB_PAGE_W];
   assign key_ok  = (wdata_i[FFB_KEY_LSB +: 8] == FFB_KEY_VALUE);
   assign code_ok = (wcmd == FFB_CMD_NOP) || (wcmd == FFB_CMD_LOCK)
                 || (wcmd == FFB_CMD_UNLOCK) || (wcmd == FFB_CMD_BIT_PGM)
                 || (wcmd == FFB_CMD_BIT_CLR) || (wcmd == FFB_CMD_BYTE_PGM)
                 || (wcmd == FFB_CMD_ALL_CLR);

   // New fuse image and the bits it would touch
   always_comb
   begin
      fuse_next  = fuse_reg;
      touch_mask = '0;
      case (wcmd)
         FFB_CMD_LOCK:
         begin
            fuse_next[wpage[FFB_PAGE_W-1 -: 4]]  = 1'b0;
            touch_mask[wpage[FFB_PAGE_W-1 -: 4]] = 1'b1;
         end
         FFB_CMD_UNLOCK:
         begin
            fuse_next[wpage[FFB_PAGE_W-1 -: 4]]  = 1'b1;
            touch_mask[wpage[FFB_PAGE_W-1 -: 4]] = 1'b1;
         end
         FFB_CMD_BIT_PGM:
         begin
            fuse_next[wpage[4:0]]  = 1'b0;
            touch_mask[wpage[4:0]] = 1'b1;
         end
         FFB_CMD_BIT_CLR:
         begin
            fuse_next[wpage[4:0]]  = 1'b1;
            touch_mask[wpage[4:0]] = 1'b1;
         end
         FFB_CMD_BYTE_PGM:
         begin
            fuse_next[{wpage[1:0], 3'h0} +: 8]  = wpage[10:3];
            touch_mask[{wpage[1:0], 3'h0} +: 8] = 8'hFF;
         end
         FFB_CMD_ALL_CLR:
         begin
            fuse_next  = FFB_FUSE_ERASED;
            touch_mask = '1;
         end
         default:
         begin
            fuse_next  = fuse_reg;
            touch_mask = '0;
         end
      endcase
   end

   assign pend_next = fuse_next;
   // Touching a guarded fuse is refused even when its value would not change
   assign guard_err =
      ((touch_mask & ffb_special_mask(security_i, tse_w)) != '0)
      || (security_i && (wcmd == FFB_CMD_BYTE_PGM) && (wpage[2:0] == FFB_GUARD_BYTE))
      || (security_i && (wcmd == FFB_CMD_ALL_CLR))
      || ((wcmd == FFB_CMD_BYTE_PGM) && (wpage[2:0] > 3'h3));

   // ==========================================================
   // Command sequencer
   // ==========================================================
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= FFB_IDLE;
         pend_reg  <= FFB_FUSE_ERASED;
         page_reg  <= '0;
         cmd_reg   <= FFB_CMD_NOP;
         timer_reg <= '0;
      end
      else
      begin
         case (state_reg)
            FFB_IDLE:
               if (cmd_wr && key_ok && code_ok && !guard_err)
               begin
                  state_reg <= FFB_BUSY;
                  pend_reg  <= pend_next;
                  page_reg  <= wpage;
                  cmd_reg   <= wcmd;
                  timer_reg <= 8'(FFB_PGM_CYC);
               end
            FFB_BUSY:
               if (timer_reg <= 8'h01)
                  state_reg <= FFB_APPLY;
               else
                  timer_reg <= timer_reg - 8'h01;
            FFB_APPLY:
               state_reg <= FFB_IDLE;
            default:
               state_reg <= FFB_IDLE;
         endcase
      end
   end

   // Fuses change only at completion so outputs never show half a command
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         fuse_reg <= FFB_FUSE_ERASED;
      else if (state_reg == FFB_APPLY)
         fuse_reg <= pend_reg;
   end

   // ==========================================================
   // Status flags; set beats the read clear
   // ==========================================================
   logic st_read;
   logic bad_set;
   logic lock_set;
   assign st_read  = rd_i && ffb_reg_hit(addr_i, FFB_OFF_STATUS);
   assign bad_set  = cmd_wr && (!key_ok || !code_ok || (state_reg != FFB_IDLE));
   assign lock_set = cmd_wr && key_ok && code_ok && (state_reg == FFB_IDLE)
                   && guard_err;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         op_done_flag_reg              <= 1'b1;
         bad_command_flag_reg          <= 1'b0;
         protection_violation_flag_reg <= 1'b0;
      end
      else
      begin
         if (cmd_wr && key_ok && code_ok && !guard_err && (state_reg == FFB_IDLE))
            op_done_flag_reg <= 1'b0;
         else if (state_reg == FFB_APPLY)
            op_done_flag_reg <= 1'b1;
         if (bad_set)
            bad_command_flag_reg <= 1'b1;
         else if (st_read)
            bad_command_flag_reg <= 1'b0;
         if (lock_set)
            protection_violation_flag_reg <= 1'b1;
         else if (st_read)
            protection_violation_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         ctrl_done_ie_reg <= 1'b0;
      else if (wr_i && ffb_reg_hit(addr_i, FFB_OFF_CTRL))
         ctrl_done_ie_reg <= wdata_i[FFB_ST_DONE];
   end

   // ==========================================================
   // Read port and registered outputs
   // ==========================================================
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         rdata_o <= '0;
      else if (rd_i)
      begin
         if (ffb_reg_hit(addr_i, FFB_OFF_CTRL))
            rdata_o <= {31'h0, ctrl_done_ie_reg};
         else if (ffb_reg_hit(addr_i, FFB_OFF_CMD))
            rdata_o <= {8'h00, page_reg, 2'h0, cmd_reg};
         else if (ffb_reg_hit(addr_i, FFB_OFF_STATUS))
            rdata_o <= {27'h0, security_i, bad_command_flag_reg,
                        protection_violation_flag_reg, 1'b0, op_done_flag_reg};
         else if (ffb_reg_hit(addr_i, FFB_OFF_FUSE_HI))
            rdata_o <= fuse_reg;
         else
            rdata_o <= '0;
      end
      else
         rdata_o <= '0;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         access_deny_o          <= 1'b0;
         region_locked_o        <= '0;
         offchip_fetch_block_o  <= 1'b0;
         trusted_state_enable_o <= 1'b0;
         trusted_debug_enable_o <= 1'b0;
         debug_window_en_o      <= 1'b0;
      end
      else
      begin
         // Boot area or locked region refuses internal array writes
         access_deny_o <= access_req_i
            && ((access_page_i < {8'h00, boot_pages_w})
                || lock_w[access_page_i[FFB_PAGE_W-1 -: 4]]);
         region_locked_o        <= lock_w;
         offchip_fetch_block_o  <= fetch_w;
         trusted_state_enable_o <= tse_w;
         trusted_debug_enable_o <= tde_w;
         debug_window_en_o      <= dbg_w;
      end
   end
endmodule
`default_nettype wire

// file: ffb_pkg.sv
`default_nettype none
package ffb_pkg;
   localparam int unsigned FFB_FUSE_W       = 32;
   localparam int unsigned FFB_LOCK_W       = 16;
   localparam int unsigned FFB_ADDR_W       = 4;
   localparam int unsigned FFB_PAGE_W       = 16;
   localparam int unsigned FFB_CMD_W        = 6;
   localparam int unsigned FFB_BOOT_W       = 3;
   // Register offsets
   localparam logic [3:0] FFB_OFF_CTRL     = 4'h0;
   localparam logic [3:0] FFB_OFF_CMD      = 4'h4;
   localparam logic [3:0] FFB_OFF_STATUS   = 4'h8;
   localparam logic [3:0] FFB_OFF_FUSE_HI  = 4'hC;
   // Command register fields
   localparam int unsigned FFB_KEY_LSB     = 24;
   localparam int unsigned FFB_PAGE_LSB    = 8;
   localparam logic [7:0]  FFB_KEY_VALUE   = 8'hA5;
   // Command codes
   localparam logic [5:0] FFB_CMD_NOP      = 6'h00;
   localparam logic [5:0] FFB_CMD_LOCK     = 6'h04;
   localparam logic [5:0] FFB_CMD_UNLOCK   = 6'h05;
   localparam logic [5:0] FFB_CMD_BIT_PGM  = 6'h07;
   localparam logic [5:0] FFB_CMD_BIT_CLR  = 6'h08;
   localparam logic [5:0] FFB_CMD_BYTE_PGM = 6'h0A;
   localparam logic [5:0] FFB_CMD_ALL_CLR  = 6'h0B;
   // Fuse positions
   localparam int unsigned FFB_FETCH_POS   = 16;
   localparam int unsigned FFB_BOOT_LSB    = 17;
   localparam int unsigned FFB_SEC_LSB     = 20;
   localparam int unsigned FFB_DBG_POS     = 22;
   localparam logic [2:0]  FFB_GUARD_BYTE  = 3'h2;
   localparam int unsigned FFB_REGION_SHIFT = 7;
   // Status bit positions
   localparam int unsigned FFB_ST_DONE     = 0;
   localparam int unsigned FFB_ST_LOCKERR  = 2;
   localparam int unsigned FFB_ST_BADCMD   = 3;
   localparam int unsigned FFB_ST_SECURE   = 4;
   // Fuse programming time
   localparam int unsigned FFB_CLK_MHZ     = 200;
   localparam int unsigned FFB_PGM_NS      = 100;
   localparam int unsigned FFB_PGM_CYC     = (FFB_PGM_NS * FFB_CLK_MHZ + 999) / 1000;
   localparam logic [FFB_FUSE_W-1:0] FFB_FUSE_ERASED = 32'hFFFFFFFF;
   typedef enum logic [1:0] {FFB_IDLE, FFB_BUSY, FFB_APPLY} ffb_state_t;
endpackage
`default_nettype wire

// file: ffb_decode.sv
`default_nettype none
module ffb_decode
   import ffb_pkg::*;
(
   input  wire logic [FFB_FUSE_W-1:0] fuse_i,           // Stored fuse bits
   output logic [FFB_LOCK_W-1:0]      region_locked_o,  // Per-region lock
   output logic                       offchip_fetch_block_o, // External fetch forbidden
   output logic [7:0]                 boot_pages_o,     // Protected page count
   output logic                       trusted_state_enable_o, // Trusted state
   output logic                       trusted_debug_enable_o, // Trusted debug
   output logic                       debug_window_en_o // Debug user protection
);
   logic [FFB_BOOT_W-1:0] boot_area_size_fuses;
   logic [1:0]            sec;
   assign boot_area_size_fuses = fuse_i[FFB_BOOT_LSB +: FFB_BOOT_W];
   assign sec = fuse_i[FFB_SEC_LSB +: 2];
   assign region_locked_o = ~fuse_i[FFB_LOCK_W-1:0];
   assign offchip_fetch_block_o = ~fuse_i[FFB_FETCH_POS];
   // Page count: 7 gives 0, each step down doubles from 2
   assign boot_pages_o = (boot_area_size_fuses == 3'h7) ? 8'h00
                       : (8'h80 >> boot_area_size_fuses);
   assign trusted_state_enable_o = sec[0] ^ sec[1];
   assign trusted_debug_enable_o = ~sec[1] & sec[0];
   assign debug_window_en_o = ~fuse_i[FFB_DBG_POS];
endmodule
`default_nettype wire

// file: ffb_fuse_ctrl_monitor.sv
`default_nettype none
module ffb_fuse_ctrl_monitor
   import ffb_pkg::*;
(
   input wire logic                  clk_i,                  // Clock
   input wire logic                  rst_n_i,                // Sync reset, active low
   input wire logic [FFB_ADDR_W-1:0] addr_i,                 // Register address
   input wire logic [31:0]           wdata_i,                // Write data
   input wire logic                  wr_i,                   // Write strobe
   input wire logic                  rd_i,                   // Read strobe
   input wire logic                  security_i,             // Security bit
   input wire logic                  access_req_i,           // Array access request
   input wire logic [31:0]           rdata_o,                // Read data
   input wire logic                  access_deny_o,          // Access refused
   input wire logic [FFB_LOCK_W-1:0] region_locked_o,        // Region locks
   input wire logic                  offchip_fetch_block_o,  // Fetch block
   input wire logic                  trusted_state_enable_o, // Trusted state
   input wire logic                  trusted_debug_enable_o, // Trusted debug
   input wire logic                  debug_window_en_o       // Debug window
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   logic       cmd_ok;
   logic [3:0] lock_idx_reg;
   assign cmd_ok = wr_i && addr_i == FFB_OFF_CMD && wdata_i[31:24] == FFB_KEY_VALUE;
   // Region index must outlive the write strobe
   always_ff @(posedge clk_i)
   begin
      if (cmd_ok)
         lock_idx_reg <= wdata_i[23:20];
   end
   // ==========================================
   // Assertions
   a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not zero outside read cycle");
   a_deny_has_cause: assert property (access_deny_o |-> $past(access_req_i))
      else $error("access refused without request");
   a_debug_needs_state: assert property (trusted_debug_enable_o |->
      trusted_state_enable_o)
      else $error("trusted debug without trusted state");
   a_secured_fuses_frozen: assert property (security_i && $past(security_i) |->
      $stable(offchip_fetch_block_o) && $stable(debug_window_en_o))
      else $error("protected fuse output changed while secured");
   a_trusted_cfg_frozen: assert property (trusted_state_enable_o &&
      $past(trusted_state_enable_o) |-> $stable(trusted_debug_enable_o))
      else $error("trusted config changed while trusted");
   a_bad_key_flagged: assert property (wr_i && addr_i == FFB_OFF_CMD &&
      wdata_i[31:24] != FFB_KEY_VALUE ##1 rd_i && addr_i == FFB_OFF_STATUS
      |=> rdata_o[FFB_ST_BADCMD])
      else $error("bad key not flagged");
   a_lock_cmd_applies: assert property (cmd_ok && wdata_i[5:0] == FFB_CMD_LOCK
      |-> ##[1:40] region_locked_o[lock_idx_reg])
      else $error("region lock command had no effect");
   a_fetch_fuse_applies: assert property (cmd_ok && wdata_i[5:0] == FFB_CMD_BIT_PGM &&
      wdata_i[23:8] == 16'h0010 && !security_i |-> ##[1:40] offchip_fetch_block_o)
      else $error("fetch fuse program had no effect");
   c_deny: cover property (access_deny_o);
   c_trusted_no_debug: cover property (trusted_state_enable_o && !trusted_debug_enable_o);
   c_secured_write: cover property (security_i && wr_i);
endmodule
bind ffb_fuse_ctrl ffb_fuse_ctrl_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .security_i(security_i),
   .access_req_i(access_req_i), .rdata_o(rdata_o), .access_deny_o(access_deny_o),
   .region_locked_o(region_locked_o), .offchip_fetch_block_o(offchip_fetch_block_o),
   .trusted_state_enable_o(trusted_state_enable_o),
   .trusted_debug_enable_o(trusted_debug_enable_o), .debug_window_en_o(debug_window_en_o));
`default_nettype wire

// file: test_ffb_fuse_ctrl.sv
`default_nettype none
module test_ffb_fuse_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import ffb_pkg::*;
   logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic security_i = 1'b0, access_req_i = 1'b0;
   logic [3:0]  addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0, rdata_o, st;
   logic [15:0] access_page_i = 16'h0, region_locked_o;
   logic access_deny_o, offchip_fetch_block_o, tse, tde, dbg;
   int num_errors = 0, n_compared = 0;
   // Commands refused while secured; the last one would leave its fuse as it is
   logic [5:0]  sc [6] = '{FFB_CMD_BIT_CLR, FFB_CMD_BIT_CLR, FFB_CMD_BIT_CLR,
                           FFB_CMD_BYTE_PGM, FFB_CMD_ALL_CLR, FFB_CMD_BIT_PGM};
   logic [15:0] sp [6] = '{16'h0010, 16'h0011, 16'h0016, 16'h05E2, 16'h0000, 16'h0010};
   always #2.5 clk_i = ~clk_i;
   ffb_fuse_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .security_i(security_i), .access_page_i(access_page_i),
      .access_req_i(access_req_i), .rdata_o(rdata_o), .access_deny_o(access_deny_o),
      .region_locked_o(region_locked_o), .offchip_fetch_block_o(offchip_fetch_block_o),
      .trusted_state_enable_o(tse), .trusted_debug_enable_o(tde), .debug_window_en_o(dbg));
   // ==========================================
   // Bus tasks, entered just after a rising edge
   task automatic test_done();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Sampled at the edge, before that edge's updates land
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      d = rdata_o;
   endtask
   // Flags clear on read, so every poll is accumulated
   task automatic cmd(input logic [5:0] c, input logic [15:0] pg, input logic [7:0] key,
                      input logic [31:0] exp);
      logic [31:0] acc;
      acc = 32'h0;
      wr(FFB_OFF_CMD, {key, pg, 2'b00, c});
      repeat (60)
      begin
         rd(FFB_OFF_STATUS, st);
         acc = acc | st;
         if (st[FFB_ST_DONE] === 1'b1)
            break;
      end
      rd(FFB_OFF_STATUS, st);
      acc = acc | st;
      chk({st[31:4], acc[3:2], st[1:0]}, exp);
   endtask
   task automatic bp(input logic [7:0] v, input logic [31:0] exp);
      cmd(FFB_CMD_BYTE_PGM, {5'h00, v, 3'h2}, FFB_KEY_VALUE, exp);
   endtask
   task automatic fuses(input logic [31:0] exp);
      rd(FFB_OFF_FUSE_HI, st);
      chk(st, exp);
   endtask
   task automatic outs(input logic [31:0] exp);
      @(posedge clk_i);
      chk({12'h000, region_locked_o, offchip_fetch_block_o, tse, tde, dbg}, exp);
   endtask
   task automatic deny(input logic [15:0] pg, input logic exp);
      access_page_i <= pg;
      access_req_i <= 1'b1;
      @(posedge clk_i);
      access_req_i <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, access_deny_o}, {31'h0, exp});
   endtask
   task automatic reset_dut();
      rst_n_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
   endtask
   // ==========================================
   // Tests
   initial
   begin
      reset_dut();
      fuses(32'hFFFFFFFF);
      outs(32'h0);
      wr(FFB_OFF_CTRL, 32'h1);
      rd(FFB_OFF_CTRL, st);
      chk(st, 32'h1);
      cmd(FFB_CMD_NOP, 16'h0000, FFB_KEY_VALUE, 32'h1);
      wr(FFB_OFF_CMD, {FFB_KEY_VALUE, 16'h0000, 2'b00, FFB_CMD_NOP});
      @(posedge clk_i);
      cmd(FFB_CMD_NOP, 16'h0000, FFB_KEY_VALUE, 32'h9);
      cmd(FFB_CMD_BIT_PGM, 16'h0010, 8'h5A, 32'h9);
      cmd(6'h3F, 16'h0000, FFB_KEY_VALUE, 32'h9);
      cmd(FFB_CMD_BIT_PGM, 16'h0010, FFB_KEY_VALUE, 32'h1);
      outs(32'h8);
      cmd(FFB_CMD_BIT_PGM, 16'h0016, FFB_KEY_VALUE, 32'h1);
      outs(32'h9);
      cmd(FFB_CMD_LOCK, 16'h3000, FFB_KEY_VALUE, 32'h1);
      outs(32'h89);
      fuses(32'hFFBEFFF7);
      deny(16'h3005, 1'b1);
      deny(16'h2005, 1'b0);
      cmd(FFB_CMD_UNLOCK, 16'h3000, FFB_KEY_VALUE, 32'h1);
      rd(FFB_OFF_CMD, st);
      chk(st, 32'h00300005);
      deny(16'h3005, 1'b0);
      bp(8'hBC, 32'h1);
      fuses(32'hFFBCFFFF);
      deny(16'h0001, 1'b1);
      deny(16'h0002, 1'b0);
      cmd(FFB_CMD_BYTE_PGM, 16'h0004, FFB_KEY_VALUE, 32'h5);
      security_i <= 1'b1;
      for (int i = 0; i < 6; i++)
         cmd(sc[i], sp[i], FFB_KEY_VALUE, 32'h15);
      fuses(32'hFFBCFFFF);
      security_i <= 1'b0;
      cmd(FFB_CMD_BIT_CLR, 16'h0011, FFB_KEY_VALUE, 32'h1);
      fuses(32'hFFBEFFFF);
      deny(16'h0001, 1'b0);
      cmd(FFB_CMD_ALL_CLR, 16'h0000, FFB_KEY_VALUE, 32'h1);
      fuses(32'hFFFFFFFF);
      bp(8'hCF, 32'h1);
      outs(32'h0);
      bp(8'hEF, 32'h1);
      outs(32'h4);
      bp(8'hDF, 32'h5);
      fuses(32'hFFEFFFFF);
      reset_dut();
      bp(8'hDF, 32'h1);
      outs(32'h6);
      test_done();
   end
   // Whole run is well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      test_done();
   end
endmodule
`default_nettype wire
